/* src/sar_conversion_core.sv */
`timescale 1ns/1ps
`include "sar_consts.svh"

// Summary of operation
// R1: a rising convert strobe ends acquisition and starts a conversion.
// R2: comparator ground switches open first, then arrays move from inputs to ground.
// R3: bits are tried MSB first toward LSB, each kept or released by comparator.
// R4: each array has 18 binary-weighted elements, one per result bit.
// R5: after the last trial return to acquisition, latch the code, pulse done.
// R6: conversion is paced by an internal tick, no serial clock needed.
// R7: the result belongs to the sample of the same strobe, no latency.
// R8: analog parts power down between conversions; strobes faster than 250 kSPS ignored.
// R9: output code is 18-bit two's complement.
// R10: over-range input gives 0x2FFFF rather than wrapping.
// R11: under-range input gives 0x20000 rather than wrapping.
// R12: the latched result stays stable until the next conversion completes.
module sar_conversion_core (
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  input  wire logic            convert_strobe,
  input  wire logic            comp_out,
  input  wire logic            over_range,
  input  wire logic            under_range,
  output logic                 pos_comparator_ground_switch,
  output logic                 neg_comparator_ground_switch,
  output logic                 sample_switch,
  output logic                 array_to_ground,
  output sar_pkg::sar_word_t   pos_array_ctrl,
  output sar_pkg::sar_word_t   neg_array_ctrl,
  output logic                 analog_power_en,
  output logic                 busy,
  output logic                 conv_done,
  output sar_pkg::sar_word_t   result
);
  import sar_pkg::*;

  typedef struct packed {
    sar_state_e  state;
    logic        strobe_d;
    sar_word_t   trial;
    sar_word_t   bitmask;
    sar_word_t   result;
    logic        done;
    logic        over;
    logic        under;
    logic [15:0] period_cnt;
    logic        gnd_sw;
    logic        samp_sw;
    logic        arr_gnd;
    sar_word_t   pos_ctrl;
    sar_word_t   neg_ctrl;
    logic        pwr_en;
    logic        busy;
  } sar_core_s;

  sar_core_s cur;
  sar_core_s next_cur;
  logic      tick;
  logic      run;
  logic      strobe_rise;
  logic      period_ok;

  // power-up contents: acquisition, ground switches closed, arrays on the inputs
  localparam sar_core_s CORE_RESET = '{
    state:      SAR_ACQ,
    strobe_d:   1'b1,
    trial:      18'h00000,
    bitmask:    18'h00000,
    result:     `SAR_CODE_ZERO,
    done:       1'b0,
    over:       1'b0,
    under:      1'b0,
    period_cnt: 16'hFFFF,
    gnd_sw:     1'b1,
    samp_sw:    1'b1,
    arr_gnd:    1'b0,
    pos_ctrl:   18'h00000,
    neg_ctrl:   18'h00000,
    pwr_en:     1'b0,
    busy:       1'b0
  };

  // phases in which the analog front end is powered and the tick runs
  function automatic logic is_active(input sar_state_e s);
    return (s == SAR_OPEN_GND) || (s == SAR_HOLD) || (s == SAR_TRIAL);
  endfunction

  // arrays stay on the inputs until the comparator side is already floating
  function automatic logic on_inputs(input sar_state_e s);
    return (s == SAR_ACQ) || (s == SAR_OPEN_GND);
  endfunction

  // arrays tied to ground from hold through the last bit trial
  function automatic logic arrays_grounded(input sar_state_e s);
    return (s == SAR_HOLD) || (s == SAR_TRIAL);
  endfunction

  // one trial: drop the bit if the trial overshoots, then raise the next lower bit;
  // after the lsb the shifted mask is zero, so only the keep or drop remains
  function automatic sar_word_t trial_step(input sar_word_t trial, input sar_word_t mask,
                                           input logic      keep);
    sar_word_t t;
    t = keep ? trial : (trial & ~mask);
    return t | (mask >> 1);
  endfunction

  // straight binary trial word to two's complement, with saturation
  function automatic sar_word_t to_code(input sar_word_t raw, input logic ovr,
                                        input logic und);
    sar_word_t c;
    c = {~raw[17], raw[16:0]};                          // R9
    if (ovr) begin
      c = `SAR_CODE_POS_FS;                             // R10
    end else if (und) begin
      c = `SAR_CODE_NEG_FS;                             // R11
    end
    return c;
  endfunction

  // conversion pace comes from the internal tick divider
  assign run = is_active(cur.state);
  sar_tick_gen u_tick (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (run),
    .tick    (tick)                                     // R6
  );

  assign strobe_rise = convert_strobe && !cur.strobe_d; // R1
  assign period_ok   = cur.period_cnt >= 16'(`SAR_MIN_PERIOD - 1); // R8

  // conversion sequencer
  always_comb begin
    next_cur = cur;
    next_cur.strobe_d = convert_strobe;
    next_cur.done = 1'b0;
    if (cur.period_cnt != 16'hFFFF) begin
      next_cur.period_cnt = cur.period_cnt + 16'h0001;
    end
    case (cur.state)
      // tracking the inputs; only a qualified strobe edge leaves
      SAR_ACQ: begin
        if (strobe_rise && period_ok) begin
          next_cur.state = SAR_OPEN_GND;                // R1
          next_cur.period_cnt = 16'h0000;
          next_cur.over = over_range;                   // R7
          next_cur.under = under_range;
        end
      end
      // comparator ground switches open while the arrays still see the inputs
      SAR_OPEN_GND: begin
        if (tick) begin
          next_cur.state = SAR_HOLD;                    // R2
        end
      end
      // arrays on ground, comparator settles on the held charge
      SAR_HOLD: begin
        if (tick) begin
          next_cur.state = SAR_TRIAL;
          next_cur.bitmask = 18'h20000;                 // R3
          next_cur.trial = 18'h20000;
        end
      end
      SAR_TRIAL: begin
        if (tick) begin
          next_cur.trial = trial_step(cur.trial, cur.bitmask, comp_out); // R3
          next_cur.bitmask = cur.bitmask >> 1;                            // R4
          if (cur.bitmask[0]) begin
            next_cur.state = SAR_DONE;
          end
        end
      end
      SAR_DONE: begin
        next_cur.result = to_code(cur.trial, cur.over, cur.under); // R5
        next_cur.done = 1'b1;                           // R5
        next_cur.state = SAR_ACQ;
        next_cur.trial = '0;
        next_cur.bitmask = '0;
      end
      default: begin
        next_cur.state = SAR_ACQ;
      end
    endcase
    // outputs follow the state this edge enters, so their timing matches a state decode
    next_cur.gnd_sw   = (next_cur.state == SAR_ACQ);                      // R2
    next_cur.samp_sw  = on_inputs(next_cur.state);                         // R2
    next_cur.arr_gnd  = arrays_grounded(next_cur.state);                   // R2
    next_cur.pos_ctrl = (next_cur.state == SAR_TRIAL) ? next_cur.trial : '0;  // R4
    next_cur.neg_ctrl = (next_cur.state == SAR_TRIAL) ? ~next_cur.trial : '0; // R4
    next_cur.pwr_en   = is_active(next_cur.state);                         // R8
    next_cur.busy     = (next_cur.state != SAR_ACQ);                       // R5
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur <= CORE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops so the analog switches never see decode glitches
  assign pos_comparator_ground_switch = cur.gnd_sw;   // R2
  assign neg_comparator_ground_switch = cur.gnd_sw;   // R2
  assign sample_switch   = cur.samp_sw;               // R2
  assign array_to_ground = cur.arr_gnd;               // R2
  assign pos_array_ctrl  = cur.pos_ctrl;              // R4
  assign neg_array_ctrl  = cur.neg_ctrl;              // R4
  assign analog_power_en = cur.pwr_en;                // R8
  assign busy      = cur.busy;                        // R5
  assign conv_done = cur.done;                        // R5
  assign result    = cur.result;                      // R12
endmodule

/* pkg/sar_consts.svh */
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// result width and code points
`define SAR_NBITS        18
`define SAR_CODE_ZERO    18'h00000
`define SAR_CODE_POS_FS  18'h2FFFF
`define SAR_CODE_NEG_FS  18'h20000

// conversion clock divider (sys_clk cycles per bit-trial tick)
`define SAR_TICK_DIV     4

// throughput limit in samples per second, and the derived minimum cycle period
`define SAR_CLK_HZ       200000000
`define SAR_MAX_SPS      250000
`define SAR_MIN_PERIOD   (`SAR_CLK_HZ / `SAR_MAX_SPS)

`endif

/* pkg/sar_pkg.sv */
package sar_pkg;
  typedef logic [17:0] sar_word_t;

  typedef enum logic [2:0] {
    SAR_ACQ,
    SAR_OPEN_GND,
    SAR_HOLD,
    SAR_TRIAL,
    SAR_DONE
  } sar_state_e;
endpackage

/* src/sar_tick_gen.sv */
`timescale 1ns/1ps
`include "sar_consts.svh"

// internal conversion clock: one-cycle enable every SAR_TICK_DIV cycles while running
module sar_tick_gen (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);
  import sar_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } sar_tick_s;

  sar_tick_s cur;
  sar_tick_s next_cur;

  // free counting only while a conversion runs
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (!run) begin
      next_cur.cnt = 8'h00;
    end else if (cur.cnt == 8'(`SAR_TICK_DIV - 1)) begin
      next_cur.cnt = 8'h00;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule

/* tb/sar_core_chk_asserts.sv */
`timescale 1ns/1ps
module sar_core_chk
  import sar_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rstn,
  input wire logic      convert_strobe,
  input wire logic      over_range,
  input wire logic      pos_comparator_ground_switch,
  input wire logic      neg_comparator_ground_switch,
  input wire logic      sample_switch,
  input wire logic      array_to_ground,
  input wire sar_word_t pos_array_ctrl,
  input wire sar_word_t neg_array_ctrl,
  input wire logic      analog_power_en,
  input wire logic      busy,
  input wire logic      conv_done,
  input wire sar_word_t result
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // start, switch order and trial words
  a_start_edge: assert property ($rose(busy) |->
    $past(convert_strobe) && !$past(convert_strobe, 2))
    else $error("start without strobe edge");
  a_gnd_first: assert property ($fell(sample_switch) |-> !$past(pos_comparator_ground_switch))
    else $error("arrays left inputs before ground opened");
  a_gnd_acq: assert property (neg_comparator_ground_switch |-> sample_switch && !array_to_ground)
    else $error("ground switch closed outside acquisition");
  a_msb_first: assert property ($rose(|pos_array_ctrl) |-> pos_array_ctrl == 18'h20000)
    else $error("first trial not msb");
  a_arrays_pair: assert property (|pos_array_ctrl |-> neg_array_ctrl == ~pos_array_ctrl)
    else $error("arrays not complementary");
  // completion timing, power and result holding
  a_conv_time: assert property ($rose(busy) |-> ##[76:86] conv_done)
    else $error("conversion length wrong");
  a_done_pulse: assert property (conv_done |=> !conv_done && !busy)
    else $error("done not single pulse");
  a_power_down: assert property (!busy |-> !analog_power_en)
    else $error("powered while idle");
  a_over_sat: assert property ($rose(busy) && $past(over_range) |->
    ##[76:86] conv_done && result == 18'h2FFFF)
    else $error("over range not saturated");
  a_result_hold: assert property (!conv_done |-> $stable(result))
    else $error("result moved without done");
endmodule
bind sar_conversion_core sar_core_chk chk (.sys_clk, .rstn, .convert_strobe, .over_range,
  .pos_comparator_ground_switch, .neg_comparator_ground_switch, .sample_switch,
  .array_to_ground, .pos_array_ctrl, .neg_array_ctrl, .analog_power_en, .busy, .conv_done,
  .result);

/* tb/sar_cmp_model.sv */
`timescale 1ns/1ps
module sar_cmp_model (
  input wire sar_pkg::sar_word_t pos_array_ctrl,
  input wire sar_pkg::sar_word_t sample,
  output logic                   comp_out
);
  import sar_pkg::*;
  // comparator: keep the trial while the trial word is not above the held sample
  always_comb begin
    comp_out = (pos_array_ctrl <= sample);
  end
endmodule

/* tb/tb_sar_conversion_core.sv */
`timescale 1ns/1ps
module tb_sar_conversion_core;
  import sar_pkg::*;
  logic      sys_clk = 0, rstn = 0, convert_strobe = 0, over_range = 0, under_range = 0;
  logic      comp_out, busy, conv_done;
  sar_word_t result, pos_ctrl, sample = 0;
  int        bad_count = 0, n_compared = 0, seed = 35392, cyc = 0;
  sar_conversion_core uut (.sys_clk, .rstn, .convert_strobe, .comp_out, .over_range,
    .under_range, .pos_comparator_ground_switch(), .neg_comparator_ground_switch(),
    .sample_switch(), .array_to_ground(), .pos_array_ctrl(pos_ctrl), .neg_array_ctrl(),
    .analog_power_en(), .busy, .conv_done, .result);
  sar_cmp_model cmp (.pos_array_ctrl(pos_ctrl), .sample, .comp_out);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // cycle ceiling against hangs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic check(input sar_word_t got, input sar_word_t exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic sar_word_t code(sar_word_t t, logic ov, logic un);
    return ov ? 18'h2FFFF : un ? 18'h20000 : t ^ 18'h20000;
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one conversion with a refused edge inside it and one just after it
  task automatic convert(sar_word_t t, logic ov, logic un);
    int k;
    sample = t;
    over_range = ov;
    under_range = un;
    convert_strobe = 1;
    step(20);
    check({17'h0, busy}, 18'h1);
    convert_strobe = 0;
    step(2);
    convert_strobe = 1;
    k = 0;
    while (conv_done !== 1'b1 && k < 100) begin
      step(1);
      k++;
    end
    check({17'h0, conv_done}, 18'h1);
    check(result, code(t, ov, un));
    step(1);
    convert_strobe = 0;
    step(1);
    convert_strobe = 1;
    step(5);
    check({17'h0, busy}, 18'h0);
    convert_strobe = 0;
    step(800);
  endtask
  initial begin
    step(10);
    rstn = 1;
    step(1);
    convert(18'h20000, 0, 0);
    convert(18'h20001, 0, 0);
    convert(18'h1FFFF, 0, 0);
    convert(18'h3FFFF, 0, 0);
    convert(18'h00000, 0, 0);
    convert(18'h12345, 1, 0);
    convert(18'h2ABCD, 0, 1);
    convert(18'h00000, 1, 1);
    repeat (8) convert(sar_word_t'($random(seed)), 0, 0);
    convert_strobe = 1; // abort a running conversion with reset
    step(30);
    rstn = 0;
    convert_strobe = 0;
    step(2);
    check(result, 18'h00000);
    check({17'h0, busy}, 18'h0);
    rstn = 1;
    step(1);
    convert(sar_word_t'($random(seed)), 0, 0);
    conclude();
  end
endmodule
